// ### src/eqr_device.sv
// equalizer control and status register bank with its control outputs
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - launch bit 7 selects 6 dB compensation
// - launch bits 6:3 give fine gain trim
// - cable length readable in bits 7:3 of 0x03
// - cable code saturates at 25, monotonic
// - general bit 2 enables extended reach
// - reset leaves normal mode, extended bit 0
// - host holds normal without carrier or long cable
// - host enters extended only carrier and short cable
// - enter: force sleep, set bit, wait, wake
// - extended mode persists until host clears it
// - leave: force sleep, clear bit, wait, wake
// - general bit 7 reads carrier status
// - mute bit 6 overrides bypass, default 0
// - bypass bit 5, default 0
// - sleep field 4:3: off, auto, force, reserved
// - sleep overrides mute and bypass
// - host writes zeros to general bits 1:0
// - host writes zeros to launch bits 2:0
module eqr_device
  import eqr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  eqr_link_if.dev link,
  input wire logic carrierPin,
  input wire logic [4:0] cableLenPin,
  output logic outMute,
  output logic outBypass,
  output logic powerDown,
  output logic extReach,
  output logic coarseComp,
  output logic [3:0] fineTrim
);
  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [5:0] pinsSync;
  eqr_sync #(.Width(6)) uSync (
    .clk(clk),
    .nrst(nrst),
    .asyncIn({carrierPin, cableLenPin}),
    .syncOut(pinsSync)
  );
  // carrier is a single level, so the plain two-stage path is enough
  wire logic carrier = pinsSync[5];
  wire logic [4:0] lenRaw = pinsSync[4:0];

  // ************************************************************
  // cable length capture
  // ************************************************************
  // the length word is synchronised bit by bit, so a code in flight can be torn;
  // a new code is taken only after two successive samples agree
  logic [4:0] lenPrev_q;
  logic [4:0] lenHeld_q;
  wire logic lenSteady = (lenRaw == lenPrev_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lenPrev_q <= 5'h00;
    end else begin
      lenPrev_q <= lenRaw;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lenHeld_q <= 5'h00;
    end else if (lenSteady) begin
      lenHeld_q <= lenRaw;
    end
  end

  // clamp keeps the code in range without breaking monotonic order
  wire logic [4:0] lenCode = (lenHeld_q > CABLE_MAX) ? CABLE_MAX : lenHeld_q;

  // ************************************************************
  // register storage
  // ************************************************************
  logic mute_q;
  logic bypass_q;
  logic [1:0] sleep_q;
  logic ext_q;
  logic coarse_q;
  logic [3:0] fine_q;
  logic [7:0] rdata_q;
  wire logic hitGen = (link.addr == REG_GENERAL);
  wire logic hitLaunch = (link.addr == REG_LAUNCH);
  wire logic hitCable = (link.addr == REG_CABLE);
  wire logic wrGen = link.wr && hitGen;
  wire logic wrLaunch = link.wr && hitLaunch;
  // write data fields of the two writable registers
  wire logic wdMute = link.wdata[GEN_MUTE_BIT];
  wire logic wdBypass = link.wdata[GEN_BYPASS_BIT];
  wire logic wdExt = link.wdata[GEN_EXT_BIT];
  wire logic wdCoarse = link.wdata[LAUNCH_COARSE_BIT];
  wire logic [3:0] wdFine = link.wdata[LAUNCH_FINE_HI:LAUNCH_FINE_LO];
  wire logic [1:0] sleepIn = link.wdata[GEN_SLEEP_HI:GEN_SLEEP_LO];
  // reserved sleep code is not stored, the previous mode stays
  wire logic sleepOk = (sleepIn != SLEEP_RSVD);
  wire logic wrSleep = wrGen && sleepOk;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mute_q <= 1'b0;
    end else if (wrGen) begin
      mute_q <= wdMute;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bypass_q <= 1'b0;
    end else if (wrGen) begin
      bypass_q <= wdBypass;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sleep_q <= SLEEP_RESET;
    end else if (wrSleep) begin
      sleep_q <= sleepIn;
    end
  end

  // only a host write changes the mode; loss of carrier does not
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_q <= 1'b0;
    end else if (wrGen) begin
      ext_q <= wdExt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      coarse_q <= 1'b0;
    end else if (wrLaunch) begin
      coarse_q <= wdCoarse;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fine_q <= 4'h0;
    end else if (wrLaunch) begin
      fine_q <= wdFine;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire logic [7:0] genVal = {carrier, mute_q, bypass_q, sleep_q, ext_q, RSVD_LOW2};
  wire logic [7:0] launchVal = {coarse_q, fine_q, RSVD_LOW3};
  wire logic [7:0] cableVal = {lenCode, RSVD_LOW3};
  // unmapped offsets read as zero
  wire logic [7:0] readMux = hitGen ? genVal :
    hitLaunch ? launchVal :
    hitCable ? cableVal :
    8'h00;

  // read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= link.rd ? readMux : 8'h00;
    end
  end
  assign link.rdata = rdata_q;

  // ************************************************************
  // control outputs
  // ************************************************************
  logic outMute_q;
  logic outBypass_q;
  logic powerDown_q;
  wire logic sleepNow = (sleep_q == SLEEP_FORCE) || ((sleep_q == SLEEP_AUTO) && !carrier);
  // sleep wins over mute, and mute over bypass
  wire logic powerDown_d = sleepNow;
  wire logic outMute_d = !sleepNow && mute_q;
  wire logic outBypass_d = !sleepNow && !mute_q && bypass_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      powerDown_q <= 1'b0;
      outMute_q <= 1'b0;
      outBypass_q <= 1'b0;
    end else begin
      powerDown_q <= powerDown_d;
      outMute_q <= outMute_d;
      outBypass_q <= outBypass_d;
    end
  end
  assign powerDown = powerDown_q;
  assign outMute = outMute_q;
  assign outBypass = outBypass_q;
  assign extReach = ext_q;
  assign coarseComp = coarse_q;
  assign fineTrim = fine_q;
endmodule : eqr_device
`default_nettype wire

// ### src/eqr_host.sv
// reach-mode host: polls the equalizer and moves it between normal and extended reach
`timescale 1ns/10ps
`default_nettype none
module eqr_host
  import eqr_pkg::*;
#(
  parameter int unsigned SettleCycles = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  eqr_link_if.host link,
  input wire logic [3:0] swAddr,
  input wire logic [31:0] swWdata,
  input wire logic swWr,
  input wire logic swRd,
  output logic [31:0] swRdata,
  output logic irq
);
  // ************************************************************
  // software registers
  // ************************************************************
  logic [31:0] ctrl_q;
  logic [4:0] launch_q;
  logic launchPend_q;
  logic [INT_WIDTH-1:0] intStat_q;
  logic [INT_WIDTH-1:0] intMask_q;
  logic [31:0] swRdata_q;
  eqr_hstate_type state_q;
  eqr_hstate_type state_d;
  logic ext_q;
  logic tgt_q;
  logic carrier_q;
  logic [4:0] len_q;
  logic [31:0] wait_q;
  logic [INT_WIDTH-1:0] intSet;

  wire logic swWrCtrl = swWr && (swAddr == HREG_CTRL);
  wire logic swWrLaunch = swWr && (swAddr == HREG_LAUNCH);
  wire logic swWrStat = swWr && (swAddr == HREG_INT_STAT);
  wire logic swWrMask = swWr && (swAddr == HREG_INT_MASK);
  wire logic [4:0] thr = ctrl_q[CTRL_THR_HI:CTRL_THR_LO];
  wire logic [1:0] wakeSleep = ctrl_q[CTRL_WAKE_AUTO_BIT] ? SLEEP_AUTO : SLEEP_OFF;
  wire logic busy = (state_q != H_IDLE);
  wire logic [31:0] statusVal = {19'h0_0000, len_q, 5'h00, busy, carrier_q, ext_q};
  wire logic [31:0] readMux = (swAddr == HREG_CTRL) ? ctrl_q :
    (swAddr == HREG_LAUNCH) ? {27'h000_0000, launch_q} :
    (swAddr == HREG_STATUS) ? statusVal :
    (swAddr == HREG_INT_STAT) ? {29'h0000_0000, intStat_q} :
    (swAddr == HREG_INT_MASK) ? {29'h0000_0000, intMask_q} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
      launch_q <= 5'h00;
      intMask_q <= '0;
      swRdata_q <= 32'h0000_0000;
    end else begin
      if (swWrCtrl) ctrl_q <= swWdata;
      if (swWrLaunch) launch_q <= swWdata[4:0];
      if (swWrMask) intMask_q <= swWdata[INT_WIDTH-1:0];
      swRdata_q <= swRd ? readMux : 32'h0000_0000;
    end
  end
  assign swRdata = swRdata_q;

  // set wins over a write-one clear in the same cycle
  wire logic [INT_WIDTH-1:0] intClr = swWrStat ? swWdata[INT_WIDTH-1:0] : '0;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      intStat_q <= '0;
    end else begin
      intStat_q <= (intStat_q & ~intClr) | intSet;
    end
  end
  assign irq = |(intStat_q & intMask_q);

  // ************************************************************
  // sequencer
  // ************************************************************
  wire logic [4:0] lenRd = link.rdata[CABLE_HI:CABLE_LO];
  wire logic goEnter = !ext_q && carrier_q && (lenRd < thr);
  wire logic goLeave = ext_q && !carrier_q;
  wire logic waitDone = (wait_q >= SettleCycles - 1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      H_IDLE: begin
        if (launchPend_q) state_d = H_LAUNCH;
        else if (ctrl_q[CTRL_EN_BIT]) state_d = H_RDGEN;
      end
      H_LAUNCH: state_d = H_IDLE;
      H_RDGEN: state_d = H_CAPGEN;
      H_CAPGEN: state_d = H_RDLEN;
      H_RDLEN: state_d = H_CAPLEN;
      H_CAPLEN: state_d = (goEnter || goLeave) ? H_SLEEP : H_IDLE;
      H_SLEEP: state_d = H_EXT;
      H_EXT: state_d = H_WAIT;
      H_WAIT: if (waitDone) state_d = H_WAKE;
      H_WAKE: state_d = H_IDLE;
    endcase
  end

  // link strobes and data are registered from the next state
  wire logic nextWrGen = (state_d == H_SLEEP) || (state_d == H_EXT) || (state_d == H_WAKE);
  wire logic nextWr = nextWrGen || (state_d == H_LAUNCH);
  wire logic nextRd = (state_d == H_RDGEN) || (state_d == H_RDLEN);
  wire logic [6:0] nextAddr = (state_d == H_LAUNCH) ? REG_LAUNCH : (state_d == H_RDLEN) ? REG_CABLE : REG_GENERAL;
  wire logic [1:0] nextSleep = (state_d == H_WAKE) ? wakeSleep : SLEEP_FORCE;
  wire logic nextExt = (state_d == H_SLEEP) ? ext_q : tgt_q;
  wire logic [7:0] genWord = {1'b0, ctrl_q[CTRL_MUTE_BIT], ctrl_q[CTRL_BYPASS_BIT], nextSleep, nextExt, RSVD_LOW2};
  wire logic [7:0] launchWord = {launch_q, RSVD_LOW3};
  wire logic [7:0] nextWdata = (state_d == H_LAUNCH) ? launchWord : nextWrGen ? genWord : 8'h00;

  logic [6:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic rd_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_q <= 7'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      addr_q <= nextAddr;
      wdata_q <= nextWdata;
      wr_q <= nextWr;
      rd_q <= nextRd;
    end
  end
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.wr = wr_q;
  assign link.rd = rd_q;

  assign intSet[INT_ENTER_BIT] = (state_q == H_WAKE) && tgt_q;
  assign intSet[INT_LEAVE_BIT] = (state_q == H_WAKE) && !tgt_q;
  assign intSet[INT_LOST_BIT] = (state_q == H_CAPGEN) && carrier_q && !link.rdata[GEN_CARRIER_BIT];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= H_IDLE;
      ext_q <= 1'b0;
      tgt_q <= 1'b0;
      carrier_q <= 1'b0;
      len_q <= 5'h00;
      wait_q <= 32'h0000_0000;
      launchPend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (swWrLaunch) launchPend_q <= 1'b1;
      else if (state_q == H_LAUNCH) launchPend_q <= 1'b0;
      if (state_q == H_CAPGEN) carrier_q <= link.rdata[GEN_CARRIER_BIT];
      if (state_q == H_CAPLEN) len_q <= lenRd;
      if (state_q == H_CAPLEN) tgt_q <= goEnter ? 1'b1 : goLeave ? 1'b0 : ext_q;
      if (state_q == H_EXT) ext_q <= tgt_q;
      wait_q <= (state_q == H_WAIT) ? wait_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
endmodule : eqr_host
`default_nettype wire

// ### src/eqr_link_if.sv
// register link between the reach-mode host and the equalizer register bank
`timescale 1ns/10ps
`default_nettype none
interface eqr_link_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : eqr_link_if
`default_nettype wire

// ### src/eqr_pkg.sv
// constants shared by the equalizer register bank and its reach-mode host
package eqr_pkg;
  // ************************************************************
  // device register map
  // ************************************************************
  localparam logic [6:0] REG_GENERAL = 7'h00;
  localparam logic [6:0] REG_LAUNCH = 7'h02;
  localparam logic [6:0] REG_CABLE = 7'h03;
  localparam int GEN_CARRIER_BIT = 7;
  localparam int GEN_MUTE_BIT = 6;
  localparam int GEN_BYPASS_BIT = 5;
  localparam int GEN_SLEEP_HI = 4;
  localparam int GEN_SLEEP_LO = 3;
  localparam int GEN_EXT_BIT = 2;
  localparam int LAUNCH_COARSE_BIT = 7;
  localparam int LAUNCH_FINE_HI = 6;
  localparam int LAUNCH_FINE_LO = 3;
  localparam int CABLE_HI = 7;
  localparam int CABLE_LO = 3;
  localparam logic [1:0] SLEEP_OFF = 2'h0;
  localparam logic [1:0] SLEEP_AUTO = 2'h1;
  localparam logic [1:0] SLEEP_FORCE = 2'h2;
  localparam logic [1:0] SLEEP_RSVD = 2'h3;
  localparam logic [1:0] SLEEP_RESET = SLEEP_AUTO;
  localparam logic [4:0] CABLE_MAX = 5'h19;
  localparam logic [2:0] RSVD_LOW3 = 3'h0;
  localparam logic [1:0] RSVD_LOW2 = 2'h0;
  // ************************************************************
  // host software registers
  // ************************************************************
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_LAUNCH = 4'h1;
  localparam logic [3:0] HREG_STATUS = 4'h2;
  localparam logic [3:0] HREG_INT_STAT = 4'h3;
  localparam logic [3:0] HREG_INT_MASK = 4'h4;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WAKE_AUTO_BIT = 1;
  localparam int CTRL_MUTE_BIT = 2;
  localparam int CTRL_BYPASS_BIT = 3;
  localparam int CTRL_THR_LO = 8;
  localparam int CTRL_THR_HI = 12;
  localparam logic [4:0] THR_RESET = 5'h12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1202;
  localparam int INT_ENTER_BIT = 0;
  localparam int INT_LEAVE_BIT = 1;
  localparam int INT_LOST_BIT = 2;
  localparam int INT_WIDTH = 3;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_MS = 1;
  localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;
  typedef enum logic [3:0] {
    H_IDLE, H_LAUNCH, H_RDGEN, H_CAPGEN, H_RDLEN, H_CAPLEN, H_SLEEP, H_EXT, H_WAIT, H_WAKE
  } eqr_hstate_type;
endpackage : eqr_pkg

// ### src/eqr_sync.sv
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module eqr_sync #(
  parameter int Width = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [Width-1:0] asyncIn,
  output logic [Width-1:0] syncOut
);
  for (genvar i = 0; i < Width; i++) begin : gBit
    logic meta_q;
    logic stab_q;
    always_ff @(posedge clk) begin
      if (!nrst) begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end else begin
        meta_q <= asyncIn[i];
        stab_q <= meta_q;
      end
    end
    assign syncOut[i] = stab_q;
  end
endmodule : eqr_sync
`default_nettype wire

// ### testbench/eqr_link_properties.sv
// link-level checks between the reach-mode host and the register bank
`timescale 1ns/10ps
`default_nettype none
module eqr_link_properties
  import eqr_pkg::*;
#(
  parameter int Settle = 20,
  parameter logic [4:0] Thr = THR_RESET
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  // ************************************************************
  // helper state: last written ext bit, last polled status, time since forced sleep
  // ************************************************************
  logic lastExt_q;
  logic lastCarrier_q;
  logic [4:0] lastLen_q;
  logic rdGen_q;
  logic rdLen_q;
  int sinceForce_q;
  wire genWr = wr && (addr == REG_GENERAL);
  wire forceWr = genWr && (wdata[GEN_SLEEP_HI:GEN_SLEEP_LO] == SLEEP_FORCE);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lastExt_q <= 1'b0;
      lastCarrier_q <= 1'b0;
      lastLen_q <= 5'h1F;
      rdGen_q <= 1'b0;
      rdLen_q <= 1'b0;
      sinceForce_q <= Settle;
    end else begin
      rdGen_q <= rd && (addr == REG_GENERAL);
      rdLen_q <= rd && (addr == REG_CABLE);
      if (genWr) lastExt_q <= wdata[GEN_EXT_BIT];
      if (rdGen_q) lastCarrier_q <= rdata[GEN_CARRIER_BIT];
      if (rdLen_q) lastLen_q <= rdata[CABLE_HI:CABLE_LO];
      if (forceWr) sinceForce_q <= 0;
      else if (sinceForce_q < Settle) sinceForce_q <= sinceForce_q + 1;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  gen_rsvd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    genWr |-> wdata[1:0] == RSVD_LOW2) else $error("general write has nonzero low bits");
  launch_rsvd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    wr && addr == REG_LAUNCH |-> wdata[2:0] == RSVD_LOW3) else $error("launch write has nonzero low bits");
  cable_read_shape_a: assert property (@(posedge clk) disable iff (!nrst)
    rd && addr == REG_CABLE |=> rdata[2:0] == RSVD_LOW3 && rdata[7:3] <= CABLE_MAX)
    else $error("cable length read out of shape");
  read_one_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
    rd ##1 !rd |=> rdata == 8'h00) else $error("read data stands too long");
  ext_under_sleep_a: assert property (@(posedge clk) disable iff (!nrst)
    genWr && wdata[GEN_EXT_BIT] != lastExt_q |-> wdata[4:3] == SLEEP_FORCE && $past(forceWr))
    else $error("reach bit changed without forced sleep first");
  wake_after_settle_a: assert property (@(posedge clk) disable iff (!nrst)
    genWr && wdata[4:3] != SLEEP_FORCE |-> sinceForce_q >= Settle - 1) else $error("wake before settle time");
  enter_when_ready_a: assert property (@(posedge clk) disable iff (!nrst)
    genWr && wdata[GEN_EXT_BIT] && !lastExt_q |-> lastCarrier_q && lastLen_q < Thr)
    else $error("extended reach entered without carrier and short cable");
  leave_on_loss_a: assert property (@(posedge clk) disable iff (!nrst)
    genWr && !wdata[GEN_EXT_BIT] && lastExt_q |-> !lastCarrier_q) else $error("extended reach left with carrier");
  sleep_code_legal_a: assert property (@(posedge clk) disable iff (!nrst)
    genWr |-> wdata[4:3] != SLEEP_RSVD) else $error("reserved sleep code written");
endmodule : eqr_link_properties
`default_nettype wire

// ### testbench/eqr_reach_regs_test.sv
// self-checking bench for the reach-mode host facing the register bank
`timescale 1ns/10ps
`default_nettype none
module eqr_reach_regs_test;
  import eqr_pkg::*;
  localparam int Settle = 20;
  typedef struct packed {logic [4:0] launch; logic [4:0] cable; logic [4:0] len;} eqr_row_type;
  eqr_row_type rows [4] = '{'{5'h00, 5'h00, 5'h00}, '{5'h1F, 5'h11, 5'h11}, '{5'h10, 5'h19, 5'h19},
    '{5'h0F, 5'h1F, 5'h19}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic carrierPin = 1'b0;
  logic [4:0] cableLenPin = 5'h00;
  logic [3:0] swAddr = 4'h0;
  logic [31:0] swWdata = 32'h0000_0000;
  logic swWr = 1'b0;
  logic swRd = 1'b0;
  logic [31:0] swRdata;
  logic [31:0] rv;
  logic irq, outMute, outBypass, powerDown, extReach, coarseComp;
  logic [3:0] fineTrim;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  eqr_link_if eqr_link_if_inst ();
  eqr_device eqr_device_inst (.clk(clk), .nrst(nrst), .link(eqr_link_if_inst.dev), .carrierPin(carrierPin),
    .cableLenPin(cableLenPin), .outMute(outMute), .outBypass(outBypass), .powerDown(powerDown),
    .extReach(extReach), .coarseComp(coarseComp), .fineTrim(fineTrim));
  eqr_host #(.SettleCycles(Settle)) eqr_host_inst (.clk(clk), .nrst(nrst), .link(eqr_link_if_inst.host),
    .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .irq(irq));
  eqr_link_properties #(.Settle(Settle)) eqr_link_properties_inst (.clk(clk), .nrst(nrst),
    .addr(eqr_link_if_inst.addr), .wdata(eqr_link_if_inst.wdata), .wr(eqr_link_if_inst.wr),
    .rd(eqr_link_if_inst.rd), .rdata(eqr_link_if_inst.rdata));
  always #2.5 clk = ~clk;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one software cycle; read data lands in rv
  task automatic sw(input logic isWr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= isWr;
    swRd <= !isWr;
    @(posedge clk);
    swWr <= 1'b0;
    swRd <= 1'b0;
    #1 rv = swRdata;
  endtask : sw
  // bounded wait for extReach (sel 0) or irq (sel 1)
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    while ((sel == 0 ? extReach : irq) !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check("wait", {31'h0, k < 2000}, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1;
  endtask : wait_hi
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      print_verdict();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check("rst outs", {28'h0, extReach, outMute, outBypass, coarseComp}, 32'h0000_0000);
    sw(0, HREG_CTRL, 32'h0000_0000);
    check("ctrl rst", rv, CTRL_RESET);
    sw(0, 4'hF, 32'h0000_0000);
    check("unmapped", rv, 32'h0000_0000);
    sw(1, HREG_INT_MASK, 32'h0000_0003);
    sw(1, HREG_CTRL, 32'h0000_1203);
    foreach (rows[i]) begin
      cableLenPin <= rows[i].cable;
      sw(1, HREG_LAUNCH, {27'h0, rows[i].launch});
      repeat (40) @(posedge clk);
      #1;
      check("launch", {27'h0, coarseComp, fineTrim}, {27'h0, rows[i].launch});
      sw(0, HREG_STATUS, 32'h0000_0000);
      check("len", {25'h0, rv[12:8], rv[1:0]}, {25'h0, rows[i].len, 2'h0});
    end
    sw(1, HREG_CTRL, 32'h0000_120F);
    cableLenPin <= 5'h05;
    carrierPin <= 1'b1;
    wait_hi(0);
    check("sleep wins", {29'h0, powerDown, outMute, outBypass}, 32'h0000_0004);
    wait_hi(1);
    check("mute wins", {29'h0, powerDown, outMute, outBypass}, 32'h0000_0002);
    sw(0, HREG_STATUS, 32'h0000_0000);
    check("status ext", {30'h0, rv[1:0]}, 32'h0000_0003);
    sw(0, HREG_INT_STAT, 32'h0000_0000);
    check("int enter", rv, 32'h0000_0001);
    sw(1, HREG_INT_STAT, 32'h0000_0001);
    check("irq clr", {31'h0, irq}, 32'h0000_0000);
    cableLenPin <= 5'h1F;
    repeat (60) @(posedge clk);
    check("persist", {31'h0, extReach}, 32'h0000_0001);
    carrierPin <= 1'b0;
    wait_hi(1);
    check("leave", {28'h0, extReach, powerDown, outMute, outBypass}, 32'h0000_0004);
    sw(0, HREG_INT_STAT, 32'h0000_0000);
    check("int leave", rv, 32'h0000_0006);
    sw(1, HREG_INT_STAT, 32'h0000_0002);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    sw(1, HREG_INT_STAT, 32'h0000_0004);
    sw(1, HREG_CTRL, 32'h0000_1209);
    cableLenPin <= THR_RESET;
    carrierPin <= 1'b1;
    repeat (80) @(posedge clk);
    check("at thr", {31'h0, extReach}, 32'h0000_0000);
    cableLenPin <= THR_RESET - 5'h01;
    wait_hi(1);
    check("bypass", {28'h0, extReach, powerDown, outMute, outBypass}, 32'h0000_0009);
    sw(1, HREG_INT_STAT, 32'h0000_0007);
    carrierPin <= 1'b0;
    wait_hi(1);
    check("sleep off", {28'h0, extReach, powerDown, outMute, outBypass}, 32'h0000_0001);
    // reset again in the middle of an entry sequence
    carrierPin <= 1'b1;
    wait_hi(0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check("rst mid", {27'h0, irq, extReach, powerDown, outMute, outBypass}, 32'h0000_0000);
    sw(0, HREG_CTRL, 32'h0000_0000);
    check("ctrl mid", rv, CTRL_RESET);
    print_verdict();
  end
endmodule : eqr_reach_regs_test
`default_nettype wire
